// ==== rtia_pkg.sv ====
// What this block does
// - Address bit 6 turns automatic reads on when one and off when zero.
// - Address bits 3 to 0 pick the internal clock register that the next access reaches.
// - Each access to a snapshot or alarm byte steps the index by one, others leave it alone.
// - The data register carries the byte written to or read from the selected register.
// - Keys 0xA5 then 0xF1 written from lock state 0x00 unlock the port, state 0x02.
// - A wrong second key sets lock state 0x03, which holds until the next reset.
// - Any key write while unlocked locks the port again.
package rtia_pkg;
	localparam logic [7:0] ADDR_LOCK = 8'h0A;
	localparam logic [7:0] ADDR_CTRL = 8'h0B;
	localparam logic [7:0] ADDR_DATA = 8'h0C;
	localparam int BIT_BUSY = 7;
	localparam int BIT_AUTO = 6;
	localparam int BIT_SHORT = 4;
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;
	localparam logic [7:0] RESET_DATA = 8'h00;
	localparam logic [3:0] RESET_INDEX = 4'h0;
	// Snapshot and alarm index ranges
	localparam logic [3:0] SNAP_FIRST = 4'h0;
	localparam logic [3:0] SNAP_LAST = 4'h3;
	localparam logic [3:0] ALARM_FIRST = 4'h8;
	localparam logic [3:0] ALARM_LAST = 4'hA;
	localparam int READ_CYCLES = 2;
	typedef enum logic [1:0] {
		RTIA_LOCKED = 2'h0,
		RTIA_KEY1 = 2'h1,
		RTIA_OPEN = 2'h2,
		RTIA_DEAD = 2'h3
	} rtia_lock_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtia_req_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] index;
		logic [7:0] wdata;
	} rtia_int_s;
endpackage

// ==== rtia_port.sv ====
`timescale 1ns/1ps
module rtia_port import rtia_pkg::*; #(
	parameter int READ_WAIT = READ_CYCLES
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Host register access
	input wire rtia_req_s i_req,
	output logic [7:0] o_rdata,
	// Internal clock register side
	output rtia_int_s o_int,
	input wire logic [7:0] i_int_rdata,
	// Status
	output logic o_short_strobe
);
	// ==========================
	// Parameter check
	if (READ_WAIT < 1 || READ_WAIT > 15) begin : g_bad_wait
		$error("READ_WAIT out of range");
	end

	// ==========================
	// Reset release
	logic [1:0] rst_sync;
	wire rst_n = rst_sync[1];
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	// ==========================
	// State
	rtia_lock_e lock;
	logic busy;
	logic auto_rd;
	logic short_en;
	logic [3:0] index;
	logic [7:0] data;
	logic [3:0] wait_cnt;

	// ==========================
	// Address decode
	wire open = (lock == RTIA_OPEN);
	wire addr_lock = (i_req.addr == ADDR_LOCK);
	wire addr_ctrl = (i_req.addr == ADDR_CTRL);
	wire addr_data = (i_req.addr == ADDR_DATA);
	wire wr_lock = i_req.wr && addr_lock;
	wire wr_ctrl = i_req.wr && addr_ctrl && open;
	// Data writes held off while busy
	wire wr_data = i_req.wr && addr_data && open && !busy;
	wire rd_data = i_req.rd && addr_data && open;

	// ==========================
	// Index classes
	// Snapshot or alarm byte
	wire idx_snap = (index >= SNAP_FIRST) && (index <= SNAP_LAST);
	wire idx_alarm = (index >= ALARM_FIRST) && (index <= ALARM_LAST);
	wire step_ok = idx_snap || idx_alarm;

	// ==========================
	// Read start and finish
	// Start from busy write
	wire start_wr = wr_ctrl && i_req.wdata[BIT_BUSY] && !busy;
	wire start_auto = rd_data && auto_rd && !busy;
	wire start = start_wr || start_auto;
	wire done = busy && (wait_cnt == 4'h1);

	// ==========================
	// Lock state machine
	rtia_lock_e next_lock;
	wire key_first_ok = wr_lock && (i_req.wdata == KEY_FIRST);
	wire key_second_ok = wr_lock && (i_req.wdata == KEY_SECOND);

	always_comb begin
		next_lock = lock;
		case (lock)
			RTIA_LOCKED: begin
				if (key_first_ok) begin
					next_lock = RTIA_KEY1;
				end
			end
			RTIA_KEY1: begin
				if (key_second_ok) begin
					next_lock = RTIA_OPEN;
				end else if (wr_lock) begin
					next_lock = RTIA_DEAD;
				end
			end
			RTIA_OPEN: begin
				if (wr_lock) begin
					next_lock = RTIA_LOCKED;
				end
			end
			RTIA_DEAD: begin
				next_lock = RTIA_DEAD;
			end
			default: begin
				next_lock = RTIA_LOCKED;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock <= RTIA_LOCKED;
		end else begin
			lock <= next_lock;
		end
	end

	// ==========================
	// Control fields
	// Auto read enable
	wire next_auto_rd = wr_ctrl ? i_req.wdata[BIT_AUTO] : auto_rd;
	wire next_short_en = wr_ctrl ? i_req.wdata[BIT_SHORT] : short_en;

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_rd <= 1'b0;
			short_en <= 1'b0;
		end else begin
			auto_rd <= next_auto_rd;
			short_en <= next_short_en;
		end
	end

	// ==========================
	// Index select and step
	// Index load when idle
	wire index_load = wr_ctrl && !busy;
	wire [3:0] index_inc = index + 4'h1;
	wire step = (done || wr_data) && step_ok;
	wire [3:0] next_index = step ? index_inc : index_load ? i_req.wdata[3:0] : index;

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			index <= RESET_INDEX;
		end else begin
			index <= next_index;
		end
	end

	// ==========================
	// Read engine
	// Busy held during read
	wire next_busy = start ? 1'b1 : (busy && !done);
	wire [3:0] wait_dec = busy ? (wait_cnt - 4'h1) : wait_cnt;
	wire [3:0] next_wait_cnt = start ? 4'(READ_WAIT) : wait_dec;

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			wait_cnt <= 4'h0;
		end else begin
			busy <= next_busy;
			wait_cnt <= next_wait_cnt;
		end
	end

	// ==========================
	// Data register
	// Read result or host byte
	wire [7:0] next_data = done ? i_int_rdata : wr_data ? i_req.wdata : data;

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data <= RESET_DATA;
		end else begin
			data <= next_data;
		end
	end

	// ==========================
	// Read back
	wire [7:0] lock_rd = {6'h00, lock};
	wire [7:0] ctrl_rd = {busy, auto_rd, 1'b0, short_en, index};
	wire [7:0] data_rd = data;

	always_comb begin
		o_rdata = 8'h00;
		case (i_req.addr)
			ADDR_LOCK: begin
				o_rdata = lock_rd;
			end
			ADDR_CTRL: begin
				o_rdata = open ? ctrl_rd : 8'h00;
			end
			ADDR_DATA: begin
				o_rdata = open ? data_rd : 8'h00;
			end
			default: begin
				o_rdata = 8'h00;
			end
		endcase
	end

	// ==========================
	// Internal register side
	// Data write forwarded
	assign o_int.wr = wr_data;
	assign o_int.rd = done;
	assign o_int.index = index;
	assign o_int.wdata = i_req.wdata;

	// ==========================
	// Status
	assign o_short_strobe = short_en;
endmodule

// ==== rtia_checker.sv ====
`timescale 1ns/1ps
module rtia_checker import rtia_pkg::*; #(
	parameter int READ_WAIT = READ_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire rtia_req_s i_req,
	input wire logic [7:0] o_rdata,
	input wire rtia_int_s o_int,
	input wire logic [7:0] i_int_rdata,
	input wire logic o_short_strobe
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	wire lk = i_req.addr == ADDR_LOCK;
	wire kw = i_req.wr && lk;
	wire st = o_int.index inside {[SNAP_FIRST:SNAP_LAST], [ALARM_FIRST:ALARM_LAST]};
	a_wr_cause: assert property (o_int.wr |-> i_req.wr && i_req.addr == ADDR_DATA)
		else $error("stray wr");
	a_index_step: assert property (o_int.rd && st |=> o_int.index == $past(o_int.index) + 4'h1)
		else $error("no step");
	a_read_gap: assert property (o_int.rd |=> !o_int.rd)
		else $error("rd twice");
	a_read_data: assert property (o_int.rd |=> i_req.addr != ADDR_DATA || o_rdata == $past(i_int_rdata))
		else $error("bad data");
	a_key_open: assert property (kw && i_req.wdata == KEY_SECOND && o_rdata == 8'h01 |=> !lk || o_rdata == 8'h02)
		else $error("no open");
	a_key_wrong: assert property (kw && i_req.wdata != KEY_SECOND && o_rdata == 8'h01 |=> !lk || o_rdata == 8'h03)
		else $error("no dead");
	a_dead_stays: assert property (lk && o_rdata == 8'h03 |=> !lk || o_rdata == 8'h03)
		else $error("left dead");
	a_relock_any: assert property (kw && o_rdata == 8'h02 |=> !lk || o_rdata == 8'h00)
		else $error("no relock");
	cover property (o_int.rd && st);
	cover property (o_int.wr);
	cover property (lk && o_rdata == 8'h03);
endmodule
bind rtia_port rtia_checker #(.READ_WAIT(READ_WAIT)) u_rtia_checker (.i_ref_clk(i_ref_clk),
	.i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata), .o_int(o_int),
	.i_int_rdata(i_int_rdata), .o_short_strobe(o_short_strobe));

// ==== rtia_regs_model.sv ====
`timescale 1ns/1ps
module rtia_regs_model import rtia_pkg::*; (
	input wire logic i_ref_clk,
	input wire rtia_int_s i_int,
	output logic [7:0] o_int_rdata
);
	logic [7:0] mem [16];
	always_ff @(posedge i_ref_clk) if (i_int.wr) mem[i_int.index] <= i_int.wdata;
	assign o_int_rdata = mem[i_int.index];
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top import rtia_pkg::*;;
	logic clk = 0, nrst = 0, strb;
	rtia_req_s req = '0;
	rtia_int_s intf;
	logic [7:0] rdata, irdata, q, m [4];
	int seed = 13, miscompares = 0, checks = 0, cyc = 0;
	always #20 clk = ~clk;
	rtia_port u_rtia_port (.i_ref_clk(clk), .i_nrst(nrst), .i_req(req), .o_rdata(rdata),
		.o_int(intf), .i_int_rdata(irdata), .o_short_strobe(strb));
	rtia_regs_model u_rtia_regs_model (.i_ref_clk(clk), .i_int(intf), .o_int_rdata(irdata));
	function automatic logic [3:0] step(input logic [3:0] i);
		return (i <= SNAP_LAST || (i >= ALARM_FIRST && i <= ALARM_LAST)) ? i + 4'h1 : i;
	endfunction
	task automatic cmp(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic acc(input logic w, r, input logic [7:0] a, d);
		@(negedge clk);
		req = '{w, r, a, d};
		#1 q = rdata;
		@(negedge clk);
		req.wr = 0;
		req.rd = 0;
	endtask
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 3000) begin
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1;
		repeat (3) @(negedge clk);
		acc(1, 0, ADDR_LOCK, KEY_FIRST);
		acc(1, 0, ADDR_LOCK, KEY_SECOND);
		acc(0, 0, ADDR_LOCK, 0);
		cmp("lock", 8'h02, q);
		acc(1, 0, ADDR_CTRL, 8'h10);
		cmp("short", 8'h01, {7'h0, strb});
		for (int i = 0; i < 4; i++) begin
			m[i] = 8'($random(seed));
			acc(1, 0, ADDR_DATA, m[i]);
		end
		acc(0, 0, ADDR_CTRL, 0);
		cmp("ctrl", {4'h1, step(4'h3)}, q);
		for (int i = 0; i < 4; i++) begin
			acc(1, 0, ADDR_CTRL, 8'h80 | 8'(i));
			acc(0, 0, ADDR_CTRL, 0);
			cmp("busy", 8'h80, q & 8'h80);
			repeat (READ_CYCLES) @(negedge clk);
			acc(0, 1, ADDR_DATA, 0);
			cmp("data", m[i], q);
		end
		acc(1, 0, ADDR_CTRL, 8'hC1);
		for (int i = 1; i < 3; i++) begin
			repeat (READ_CYCLES + 1) @(negedge clk);
			acc(0, 1, ADDR_DATA, 0);
			cmp("auto", m[i], q);
		end
		repeat (READ_CYCLES + 1) @(negedge clk);
		acc(0, 0, ADDR_CTRL, 0);
		cmp("ctrl", 8'h44, q);
		acc(1, 0, ADDR_CTRL, 8'h05);
		acc(1, 0, ADDR_DATA, 8'($random(seed)));
		acc(0, 0, ADDR_CTRL, 0);
		cmp("ctrl", {4'h0, step(4'h5)}, q);
		acc(1, 0, ADDR_LOCK, 8'h00);
		acc(0, 0, ADDR_LOCK, 0);
		cmp("lock", 8'h00, q);
		acc(1, 0, ADDR_LOCK, KEY_FIRST);
		acc(1, 0, ADDR_LOCK, 8'h00);
		acc(1, 0, ADDR_LOCK, KEY_FIRST);
		acc(1, 0, ADDR_LOCK, KEY_SECOND);
		acc(0, 0, ADDR_LOCK, 0);
		cmp("lock", 8'h03, q);
		@(negedge clk);
		nrst = 0;
		repeat (2) @(negedge clk);
		nrst = 1;
		repeat (3) @(negedge clk);
		acc(0, 0, ADDR_LOCK, 0);
		cmp("lock", 8'h00, q);
		acc(1, 0, ADDR_LOCK, KEY_FIRST);
		acc(1, 0, ADDR_LOCK, KEY_SECOND);
		acc(0, 0, ADDR_CTRL, 0);
		cmp("ctrl", 8'h00, q);
		wrap_up();
	end
endmodule
